/* src/serial_channel.v */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.vh"

module serial_channel #(
   parameter DIV_W = 16
) (
   input wire clk,
   input wire srst,
   input wire [DIV_W-1:0] baud_div,
   input wire tx_enable,
   input wire loopback,
   input wire rx_pin,
   input wire grant_pin,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output reg tx_ready,
   output reg [7:0] rx_data,
   output reg rx_valid,
   output reg frame_err,
   output reg tx_line,
   output reg request_line
);
   localparam TX_IDLE = 2'h0;
   localparam TX_WAIT = 2'h1;
   localparam TX_SHIFT = 2'h2;
   localparam RX_IDLE = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_DATA = 2'h2;
   localparam RX_STOP = 2'h3;

   reg [DIV_W-1:0] div_cnt_r;
   reg tick_r;
   reg [1:0] tx_state_r;
   reg [3:0] tx_tick_r;
   reg [3:0] tx_bit_r;
   reg [9:0] tx_shift_r;
   reg tx_serial_r;
   reg [1:0] rx_state_r;
   reg [3:0] rx_tick_r;
   reg [3:0] rx_bit_r;
   reg [7:0] rx_shift_r;
   reg rx_in;

   // Serial clock source: rising half at tick 0..7 of a bit, falling half at 8
   always @(posedge clk) begin
      if (srst || div_cnt_r == baud_div) begin
         div_cnt_r <= {DIV_W{1'b0}};
         tick_r <= ~srst;
      end else begin
         div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end

   // Loopback feeds the receiver from the transmitter, not the pin
   always @* begin
      rx_in = loopback ? tx_serial_r : rx_pin;
   end

   always @(posedge clk) begin
      if (srst) begin
         tx_state_r <= TX_IDLE;
         tx_tick_r <= 4'h0;
         tx_bit_r <= 4'h0;
         tx_shift_r <= {10{`SP_LINE_IDLE}};
         tx_serial_r <= `SP_LINE_IDLE;
         tx_ready <= 1'b0;
         request_line <= 1'b0;
         tx_line <= `SP_LINE_IDLE;
      end else begin
         tx_ready <= 1'b0;
         // Pin stays high when idle, disabled or looped back [R4] [R5]
         tx_line <= (loopback || !tx_enable) ? `SP_LINE_IDLE : tx_serial_r;
         case (tx_state_r)
            TX_IDLE: begin
               tx_serial_r <= `SP_LINE_IDLE; // [R4]
               request_line <= 1'b0;
               if (tx_enable && tx_valid) begin
                  // Stop, data LSB first, start [R9] [R3]
                  tx_shift_r <= {`SP_LINE_IDLE, tx_data, `SP_START_LVL};
                  tx_ready <= 1'b1;
                  request_line <= 1'b1; // [R6]
                  tx_state_r <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               // Loopback needs no peer, so grant is implied there
               if (!tx_enable) begin
                  tx_state_r <= TX_IDLE;
               end else if ((grant_pin || loopback) && tick_r &&
                            tx_tick_r == `SP_EDGE_TICK) begin // [R6] [R7]
                  tx_serial_r <= tx_shift_r[0]; // [R3]
                  tx_shift_r <= {`SP_LINE_IDLE, tx_shift_r[9:1]};
                  tx_bit_r <= 4'h0;
                  tx_tick_r <= 4'h0;
                  tx_state_r <= TX_SHIFT;
               end else if (tick_r) begin
                  tx_tick_r <= tx_tick_r + 4'h1;
               end
            end
            TX_SHIFT: begin
               if (!tx_enable) begin
                  tx_state_r <= TX_IDLE;
               end else if (tick_r) begin
                  tx_tick_r <= tx_tick_r + 4'h1;
                  if (tx_tick_r == `SP_OVERSAMPLE) begin
                     if (tx_bit_r == `SP_DATA_BITS + 4'h1) begin
                        tx_state_r <= TX_IDLE;
                     end else begin
                        // Change only on the falling phase of the bit clock [R3]
                        tx_serial_r <= tx_shift_r[0];
                        tx_shift_r <= {`SP_LINE_IDLE, tx_shift_r[9:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                     end
                  end
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         rx_state_r <= RX_IDLE;
         rx_tick_r <= 4'h0;
         rx_bit_r <= 4'h0;
         rx_shift_r <= 8'h00;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         frame_err <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         frame_err <= 1'b0;
         case (rx_state_r)
            RX_IDLE: begin
               rx_tick_r <= 4'h0;
               if (rx_in == `SP_START_LVL) begin
                  rx_state_r <= RX_START;
               end
            end
            RX_START: begin
               if (tick_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  // Sample at bit centre, on the rising phase [R2]
                  if (rx_tick_r == `SP_MID_TICK) begin
                     if (rx_in == `SP_START_LVL) begin // [R9]
                        rx_bit_r <= 4'h0;
                        rx_tick_r <= 4'h0;
                        rx_state_r <= RX_DATA;
                     end else begin
                        rx_state_r <= RX_IDLE;
                     end
                  end
               end
            end
            RX_DATA: begin
               if (tick_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  if (rx_tick_r == `SP_OVERSAMPLE) begin
                     rx_shift_r <= {rx_in, rx_shift_r[7:1]}; // [R2]
                     rx_bit_r <= rx_bit_r + 4'h1;
                     if (rx_bit_r == `SP_DATA_BITS - 4'h1) begin
                        rx_state_r <= RX_STOP;
                     end
                  end
               end
            end
            RX_STOP: begin
               if (tick_r) begin
                  rx_tick_r <= rx_tick_r + 4'h1;
                  if (rx_tick_r == `SP_OVERSAMPLE) begin
                     rx_data <= rx_shift_r;
                     rx_valid <= (rx_in == `SP_LINE_IDLE); // [R9]
                     frame_err <= (rx_in != `SP_LINE_IDLE);
                     rx_state_r <= RX_IDLE;
                  end
               end
            end
            default: rx_state_r <= RX_IDLE;
         endcase
      end
   end
endmodule // serial_channel

`default_nettype wire

/* src/serial_port_regs.vh */
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH

// Default divider from clk to the 16x oversampling tick
`define SP_BAUD_DIV_DEF 16'h0004
// Last tick index of a bit; a bit spans 16 ticks
`define SP_OVERSAMPLE 4'hf
// Tick index of the bit centre, where the receiver samples
`define SP_MID_TICK 4'h7
// Tick index of the half-bit point, where the transmit line starts the start bit
`define SP_EDGE_TICK 4'h8
// Data bits per character
`define SP_DATA_BITS 4'h8
// Idle and stop level of the line
`define SP_LINE_IDLE 1'b1
// Start bit level
`define SP_START_LVL 1'b0

`endif

/* src/dual_serial_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_regs.vh"

// What this block does
// R1: Two independent channels, own rx and tx
// R2: Receiver samples rising phase, LSB first
// R3: Transmitter shifts falling phase, LSB first
// R4: Idle or disabled transmit line is high
// R5: Loopback holds the transmit pin high
// R6: Raise send request, then await grant
// R7: Transmission starts only after peer grant; in loopback the channel starts without one
// R8: Pins selected as general purpose lose serial
// R9: Low start bit, high stop bit framing
module dual_serial_port #(
   parameter DIV_W = 16,
   parameter [DIV_W-1:0] BAUD_DIV = `SP_BAUD_DIV_DEF
) (
   input wire clk,
   input wire srst,
   input wire [1:0] tx_enable,
   input wire [1:0] loopback,
   input wire [3:0] pin_select_a,
   input wire [3:0] pin_select_b,
   input wire [3:0] gp_out,
   input wire serial_rx_pin_a,
   input wire serial_rx_pin_b,
   input wire send_grant_pin_a,
   input wire send_grant_pin_b,
   input wire [7:0] tx_data_a,
   input wire tx_valid_a,
   input wire [7:0] tx_data_b,
   input wire tx_valid_b,
   output reg tx_ready_a,
   output reg tx_ready_b,
   output reg [7:0] rx_data_a,
   output reg rx_valid_a,
   output reg frame_err_a,
   output reg [7:0] rx_data_b,
   output reg rx_valid_b,
   output reg frame_err_b,
   output reg serial_tx_pin_a,
   output reg serial_tx_pin_b,
   output reg send_request_pin_a,
   output reg send_request_pin_b,
   output reg [3:0] gp_in
);
   // pin_select bits: 0 rx, 1 tx, 2 request, 3 grant; 1 means general purpose
   wire [7:0] rxd_a;
   wire [7:0] rxd_b;
   wire [1:0] rxv;
   wire [1:0] ferr;
   wire [1:0] txl;
   wire [1:0] rql;
   wire [1:0] txr;

   // A pin taken for general purpose reads idle to the serial logic [R8]
   function idle_if;
      input sel;
      input pin;
      input idle;
      begin
         idle_if = sel ? idle : pin;
      end
   endfunction

   serial_channel #(.DIV_W(DIV_W)) u_ch_a ( // [R1]
      .clk(clk),
      .srst(srst),
      .baud_div(BAUD_DIV),
      .tx_enable(tx_enable[0] & ~pin_select_a[1]), // [R8]
      .loopback(loopback[0]),
      .rx_pin(idle_if(pin_select_a[0], serial_rx_pin_a, `SP_LINE_IDLE)),
      .grant_pin(idle_if(pin_select_a[3], send_grant_pin_a, 1'b0)),
      .tx_data(tx_data_a),
      .tx_valid(tx_valid_a),
      .tx_ready(txr[0]),
      .rx_data(rxd_a),
      .rx_valid(rxv[0]),
      .frame_err(ferr[0]),
      .tx_line(txl[0]),
      .request_line(rql[0])
   );

   serial_channel #(.DIV_W(DIV_W)) u_ch_b ( // [R1]
      .clk(clk),
      .srst(srst),
      .baud_div(BAUD_DIV),
      .tx_enable(tx_enable[1] & ~pin_select_b[1]), // [R8]
      .loopback(loopback[1]),
      .rx_pin(idle_if(pin_select_b[0], serial_rx_pin_b, `SP_LINE_IDLE)),
      .grant_pin(idle_if(pin_select_b[3], send_grant_pin_b, 1'b0)),
      .tx_data(tx_data_b),
      .tx_valid(tx_valid_b),
      .tx_ready(txr[1]),
      .rx_data(rxd_b),
      .rx_valid(rxv[1]),
      .frame_err(ferr[1]),
      .tx_line(txl[1]),
      .request_line(rql[1])
   );

   // Outputs re-registered; the one-cycle lag is the price of flop-driven pins
   always @(posedge clk) begin
      if (srst) begin
         tx_ready_a <= 1'b0;
         tx_ready_b <= 1'b0;
         rx_data_a <= 8'h00;
         rx_valid_a <= 1'b0;
         frame_err_a <= 1'b0;
         rx_data_b <= 8'h00;
         rx_valid_b <= 1'b0;
         frame_err_b <= 1'b0;
         serial_tx_pin_a <= `SP_LINE_IDLE;
         serial_tx_pin_b <= `SP_LINE_IDLE;
         send_request_pin_a <= 1'b0;
         send_request_pin_b <= 1'b0;
         gp_in <= 4'h0;
      end else begin
         tx_ready_a <= txr[0];
         tx_ready_b <= txr[1];
         rx_data_a <= rxd_a;
         rx_valid_a <= rxv[0];
         frame_err_a <= ferr[0];
         rx_data_b <= rxd_b;
         rx_valid_b <= rxv[1];
         frame_err_b <= ferr[1];
         serial_tx_pin_a <= pin_select_a[1] ? gp_out[0] : txl[0]; // [R8]
         serial_tx_pin_b <= pin_select_b[1] ? gp_out[1] : txl[1]; // [R8]
         send_request_pin_a <= pin_select_a[2] ? gp_out[2] : rql[0]; // [R8]
         send_request_pin_b <= pin_select_b[2] ? gp_out[3] : rql[1]; // [R8]
         gp_in <= {send_grant_pin_b, send_grant_pin_a, serial_rx_pin_b, serial_rx_pin_a};
      end
   end
endmodule // dual_serial_port

`default_nettype wire

/* dv/dual_serial_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_pins_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] tx_enable,
   input wire logic [1:0] loopback,
   input wire logic [3:0] pin_select_a,
   input wire logic [3:0] gp_out,
   input wire logic tx_valid_a,
   input wire logic tx_ready_a,
   input wire logic rx_valid_a,
   input wire logic serial_tx_pin_a,
   input wire logic send_request_pin_a,
   input wire logic send_grant_pin_a,
   input wire logic serial_rx_pin_a,
   input wire logic serial_rx_pin_b,
   input wire logic send_grant_pin_b,
   input wire logic [3:0] gp_in
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_start;
      $fell(serial_tx_pin_a) && !pin_select_a[1] && tx_enable[0];
   endsequence
   sequence s_low;
      (!serial_tx_pin_a) [*7];
   endsequence
   property p_idle;
      (!tx_enable[0] && !pin_select_a[1]) [*3] |-> serial_tx_pin_a;
   endproperty
   property p_loop;
      (loopback[0] && !pin_select_a[1]) [*3] |-> serial_tx_pin_a;
   endproperty
   property p_gptx;
      pin_select_a[1] [*2] ##0 $stable(gp_out[0]) |-> serial_tx_pin_a == gp_out[0];
   endproperty
   property p_gprq;
      pin_select_a[2] [*2] ##0 $stable(gp_out[2]) |-> send_request_pin_a == gp_out[2];
   endproperty
   property p_ready;
      tx_ready_a |-> (send_request_pin_a && $past(tx_valid_a, 2)) ##1 !tx_ready_a;
   endproperty
   property p_start;
      s_start |-> (send_request_pin_a && send_grant_pin_a) ##1 s_low;
   endproperty
   property p_rxv;
      rx_valid_a |=> !rx_valid_a;
   endproperty
   property p_gpin;
      !$past(srst) |-> gp_in[0] == $past(serial_rx_pin_a) &&
         gp_in[1] == $past(serial_rx_pin_b) && gp_in[2] == $past(send_grant_pin_a) &&
         gp_in[3] == $past(send_grant_pin_b);
   endproperty
   property p_rqend;
      $fell(send_request_pin_a) && tx_enable[0] && !pin_select_a[2] |-> serial_tx_pin_a;
   endproperty
   a_idle: assert property (p_idle) else $error("tx pin not high");
   a_loop: assert property (p_loop) else $error("loopback tx pin not high");
   a_gptx: assert property (p_gptx) else $error("gp tx pin wrong");
   a_gprq: assert property (p_gprq) else $error("gp request pin wrong");
   a_ready: assert property (p_ready) else $error("accept pulse wrong");
   a_start: assert property (p_start) else $error("start bit wrong");
   a_rxv: assert property (p_rxv) else $error("rx valid not a pulse");
   a_gpin: assert property (p_gpin) else $error("gp input wrong");
   a_rqend: assert property (p_rqend) else $error("request fell mid frame");
endmodule // serial_pins_checker
bind dual_serial_port serial_pins_checker chk_u (.clk, .srst, .tx_enable, .loopback,
   .pin_select_a, .gp_out, .tx_valid_a, .tx_ready_a, .rx_valid_a, .serial_tx_pin_a,
   .send_request_pin_a, .send_grant_pin_a, .serial_rx_pin_a, .serial_rx_pin_b,
   .send_grant_pin_b, .gp_in);
`default_nettype wire

/* dv/serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
   parameter int BIT = 16
) (
   input wire logic clk,
   input wire logic req,
   input wire logic tx,
   input wire logic [7:0] lag,
   input wire logic go,
   input wire logic [7:0] sb,
   input wire logic stp,
   output logic grant,
   output logic rx,
   output logic [7:0] got,
   output logic [7:0] n
);
   logic [7:0] w;
   initial begin
      grant = 0;
      rx = 1;
      got = 0;
      n = 0;
      w = 0;
   end
   // Grant rises lag+1 cycles after request, to model a slow peer
   always @(posedge clk) begin
      w <= !req ? 8'h00 : (w == lag) ? w : w + 8'h01;
      grant <= req && (w == lag);
   end
   always @(posedge clk) begin
      if (go) begin
         rx <= 1'b0;
         repeat (BIT) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            rx <= sb[i];
            repeat (BIT) @(posedge clk);
         end
         // Stop level is chosen by the bench, so a framing fault can be sent
         rx <= stp;
         repeat (BIT) @(posedge clk);
         rx <= 1'b1;
      end
   end
   // A character with a low stop bit is not counted, so the bench times out
   always begin
      @(negedge tx);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         got[i] = tx;
      end
      repeat (BIT) @(posedge clk);
      if (tx) n = n + 8'h01;
   end
endmodule // serial_peer
`default_nettype wire

/* dv/dual_serial_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_serial_port_tb;
   logic clk = 0, srst = 1, tva = 0, tvb = 0, go = 0, stp = 1, rxa, rxb, gra, grb;
   logic [1:0] tx_enable = 0, loopback = 0;
   logic [3:0] psa = 0, psb = 0, gpo = 0, gp_in;
   logic [7:0] tda = 0, tdb = 0, rda, rdb, lag = 0, sb = 0, ga, gb, na, nb;
   logic ra, rb, rva, rvb, txa, txb, rqa, rqb, fea, feb;
   int mismatches = 0, n_compared = 0, k;
   wire [1:0] rdy = {rb, ra};
   wire [1:0] txs = {txb, txa};
   wire [1:0] grs = {grb, gra};
   always #50 clk = ~clk;
   dual_serial_port #(.BAUD_DIV(16'h0000)) dut_u (.clk(clk), .srst(srst),
      .tx_enable(tx_enable), .loopback(loopback), .pin_select_a(psa),
      .pin_select_b(psb), .gp_out(gpo), .serial_rx_pin_a(rxa), .serial_rx_pin_b(rxb),
      .send_grant_pin_a(gra), .send_grant_pin_b(grb), .tx_data_a(tda), .tx_valid_a(tva),
      .tx_data_b(tdb), .tx_valid_b(tvb), .tx_ready_a(ra), .tx_ready_b(rb),
      .rx_data_a(rda), .rx_valid_a(rva), .frame_err_a(fea), .rx_data_b(rdb),
      .rx_valid_b(rvb), .frame_err_b(feb), .serial_tx_pin_a(txa), .serial_tx_pin_b(txb),
      .send_request_pin_a(rqa), .send_request_pin_b(rqb), .gp_in(gp_in));
   serial_peer pa (.clk(clk), .req(rqa), .tx(txa), .lag(lag), .go(go), .sb(sb), .stp(stp),
      .grant(gra), .rx(rxa), .got(ga), .n(na));
   serial_peer pb (.clk(clk), .req(rqb), .tx(txb), .lag(lag), .go(go), .sb(~sb), .stp(stp),
      .grant(grb), .rx(rxb), .got(gb), .n(nb));
   task ck(input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task close_out;
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task bound(input int lim);
      if (k >= lim) begin
         mismatches++;
         close_out;
      end
   endtask
   task t_send(input int ch, input logic [7:0] d, input logic [7:0] l);
      logic [7:0] n0;
      n0 = ch ? nb : na;
      @(posedge clk);
      lag <= l;
      tda <= d;
      tdb <= d;
      tva <= ch == 0;
      tvb <= ch == 1;
      for (k = 0; k < 40 && !rdy[ch]; k++) @(negedge clk);
      bound(40);
      ck(rdy[ch] & (ch ? rqb : rqa), 1);
      @(posedge clk);
      tva <= 0;
      tvb <= 0;
      for (k = 0; k < 900 && (ch ? nb : na) == n0; k++) begin
         @(negedge clk);
         ck(!txs[ch] && !grs[ch], 0);
      end
      bound(900);
      ck(ch ? gb : ga, d);
   endtask
   task t_recv(input logic [7:0] d, input logic s);
      logic [1:0] seen, bad;
      seen = 0;
      bad = 0;
      @(posedge clk);
      sb <= d;
      stp <= s;
      go <= 1;
      @(posedge clk);
      go <= 0;
      for (k = 0; k < 400 && (seen | bad) != 2'b11; k++) begin
         @(negedge clk);
         seen = seen | {rvb, rva};
         bad = bad | {feb, fea};
      end
      bound(400);
      ck({seen, bad}, s ? 8'h0c : 8'h03);
      ck(rda, d);
      ck(rdb, ~d);
      // Peer still owns the line for the rest of its stop bit
      repeat (20) @(posedge clk);
   endtask
   task t_loop(input logic [7:0] d);
      logic [1:0] seen;
      seen = 0;
      @(posedge clk);
      loopback <= 2'b11;
      tda <= d;
      tdb <= ~d;
      tva <= 1;
      tvb <= 1;
      for (k = 0; k < 40 && rdy != 2'b11; k++) @(negedge clk);
      bound(40);
      @(posedge clk);
      tva <= 0;
      tvb <= 0;
      for (k = 0; k < 900 && seen != 2'b11; k++) begin
         @(negedge clk);
         seen = seen | {rvb, rva};
         ck({txb, txa}, 8'h03);
      end
      bound(900);
      ck(rda, d);
      ck(rdb, ~d);
      @(posedge clk);
      loopback <= 2'b00;
   endtask
   task t_refuse;
      @(posedge clk);
      tx_enable <= 2'b10;
      tva <= 1;
      repeat (20) @(negedge clk);
      ck({ra, txa}, 1);
      @(posedge clk);
      tx_enable <= 2'b11;
      tvb <= 1;
      psa <= 4'hf;
      psb <= 4'hf;
      gpo <= 4'hc;
      repeat (20) @(negedge clk);
      // Request pins driven high by hand still earn a grant from the peers
      ck({ra, txa, rqa, gp_in}, 8'h1f);
      ck({rb, txb, rqb}, 8'h01);
      @(posedge clk);
      tva <= 0;
      tvb <= 0;
      psa <= 4'h0;
      psb <= 4'h0;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      srst <= 0;
      tx_enable <= 2'b11;
      @(negedge clk);
      ck({txa, txb, rqa, rqb}, 8'h0c);
      t_send(0, 8'ha5, 8'h28);
      t_send(1, 8'h3c, 8'h00);
      t_send(0, 8'h01, 8'h00);
      t_recv(8'h96, 1'b1);
      t_recv(8'h69, 1'b0);
      t_loop(8'h5a);
      t_refuse;
      close_out;
   end
endmodule // dual_serial_port_tb
`default_nettype wire
